// ==== core/control_mode_strap_decode.sv ====
// Strap decoder that picks the device control mode and pin roles
`timescale 1ns/1ps
`default_nettype none
`include "strap_regs.svh"
// Operation
// - Mode pin low/mid/high picks hardware/serial/parallel
// - Serial mode enables only serial port pins
// - Parallel mode enables address, data, strobe pins
// - Mode 100, 101, 111 select parallel variants
// - Multiplex pin high selects shared bus
// - Family pin picks data strobe or strobes
// - Hardware line code: low zero-substitution, high AMI
// - Jitter attenuator low transmit, mid receive
// - Hardware mode takes config from its pins
// - Muxed strobes mode latches low five lines
module control_mode_strap_decode
  import strap_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] control_mode_select_hi,  // Three-level code
  input  wire logic       bus_multiplex_select,
  input  wire logic       host_family_select,      // Shared with line code
  input  wire logic [1:0] chip_select_ja_level,    // Three-level code of shared pin
  input  wire logic [2:0] template_select,
  input  wire logic [7:0] loopback_select,
  input  wire logic       clock_edge_select,
  input  wire logic       output_enable_pin,
  input  wire logic [7:0] shared_bus,              // Address/data lines
  input  wire logic       address_latch_strobe,
  output logic            straps_ready_ff,
  output ctrl_mode_t      ctrl_mode_ff,
  output par_style_t      par_style_ff,
  output logic            serial_port_en_ff,
  output logic            parallel_port_en_ff,
  output logic            hw_config_en_ff,
  output logic            ami_select_ff,
  output ja_pos_t         ja_pos_ff,
  output logic [2:0]      hw_template_ff,
  output logic [7:0]      hw_loopback_ff,
  output logic            hw_clock_edge_ff,
  output logic            hw_output_enable_ff,
  output logic            chip_select_n_ff,
  output logic [4:0]      latched_address_ff
);

  // Decode a three-level code into a control mode; code 3 counts as high
  // The pad comparators deliver each three-level pin as a two-bit code;
  // this block only interprets that code
  function automatic ctrl_mode_t level_to_mode(input logic [1:0] lvl);
    case (lvl)
      `LVL_LOW: level_to_mode = CTRL_HARDWARE;  // Pin tied low
      `LVL_MID: level_to_mode = CTRL_SERIAL;    // Pin left at mid-supply
      default:  level_to_mode = CTRL_PARALLEL;  // Pin tied high
    endcase
  endfunction : level_to_mode

  // True when the strap code selects hardware mode
  function automatic logic hw_config_en_sel(input logic [1:0] lvl);
    hw_config_en_sel = (lvl == `LVL_LOW);
  endfunction : hw_config_en_sel

  // Local state
  strap_state_t state_ff;       // Startup sequencer state
  strap_state_t nxt_state;      // Next sequencer state
  logic [7:0]   settle_cnt_ff;  // Startup settling counter
  logic         ale_q_ff;       // Previous latch strobe level

  // Startup sequencer: wait for the straps to settle, then sample once.
  // The straps are read on a single edge only, so the shared pin later
  // toggling as chip select never disturbs the chosen mode.
  always_comb begin
    nxt_state = state_ff;  // Hold by default
    // One-hot codes; any other code is caught by the default branch
    case (state_ff)
      // First edge after reset starts the settling wait
      ST_RESET: begin
        nxt_state = ST_SETTLE;
      end
      // Leave on the last settling cycle
      ST_SETTLE: begin
        if (settle_cnt_ff == 8'(`SETTLE_CYCLES - 1)) begin
          nxt_state = ST_READY;
        end
      end
      // Straps stay sampled until the next reset
      ST_READY: begin
        nxt_state = ST_READY;
      end
      // Unused code: start over
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
  end

  // State register; reset restarts the whole strap sequence
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_RESET;  // Restart the strap sampling
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Settling counter; it only runs while settling, so it never wraps
  // Eight bits leave room for a longer settling time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt_ff <= 8'h00;
    end else if (state_ff == ST_SETTLE) begin
      settle_cnt_ff <= settle_cnt_ff + 8'h01;  // Count one settling cycle
    end
  end

  // Strap capture at the end of settling. Every mode output changes on the
  // same edge as the ready flag, so a user never sees a half-decoded mode.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Out of reset: hardware mode, host ports off
      straps_ready_ff     <= 1'h0;
      ctrl_mode_ff        <= CTRL_HARDWARE;
      par_style_ff        <= '0;
      serial_port_en_ff   <= 1'h0;
      parallel_port_en_ff <= 1'h0;
      hw_config_en_ff     <= 1'h0;
      ami_select_ff       <= 1'h0;
      ja_pos_ff           <= JA_NONE;
    end else if (state_ff == ST_SETTLE && nxt_state == ST_READY) begin
      // Sample every strap on the one edge that ends settling
      straps_ready_ff     <= 1'h1;
      ctrl_mode_ff        <= level_to_mode(control_mode_select_hi);
      // Exactly one of the three pin groups is enabled
      serial_port_en_ff   <= level_to_mode(control_mode_select_hi) == CTRL_SERIAL;
      parallel_port_en_ff <= level_to_mode(control_mode_select_hi) == CTRL_PARALLEL;
      hw_config_en_ff     <= level_to_mode(control_mode_select_hi) == CTRL_HARDWARE;
      if (level_to_mode(control_mode_select_hi) == CTRL_PARALLEL) begin
        // Variant bits follow the multiplex and family pins one for one,
        // which covers the three listed variants and the unlisted one alike
        par_style_ff.multiplexed <= bus_multiplex_select;
        par_style_ff.rw_strobes  <= host_family_select;
      end else begin
        par_style_ff <= '0;  // No parallel variant outside parallel mode
      end
      // Line code only means something in hardware mode; else zero-substitution
      ami_select_ff <= hw_config_en_sel(control_mode_select_hi)
                       & host_family_select;
      // Jitter attenuator position from the shared three-level pin
      if (level_to_mode(control_mode_select_hi) != CTRL_HARDWARE) begin
        ja_pos_ff <= JA_NONE;      // Pin is chip select in host modes
      end else if (chip_select_ja_level == `LVL_LOW) begin
        ja_pos_ff <= JA_TRANSMIT;
      end else if (chip_select_ja_level == `LVL_MID) begin
        ja_pos_ff <= JA_RECEIVE;
      end else begin
        // High level leaves the attenuator out of both paths
        ja_pos_ff <= JA_NONE;
      end
    end
  end

  // Hardware mode configuration pins follow live while enabled, one cycle
  // late; in host modes they keep their reset values so stray pin activity
  // (the same pins carry host strobes) cannot leak into the line setup
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hw_template_ff      <= 3'h0;
      hw_loopback_ff      <= 8'h00;
      hw_clock_edge_ff    <= 1'h0;
      hw_output_enable_ff <= 1'h0;
    end else if (hw_config_en_ff) begin
      // Only the enable gates the update; the pins themselves are levels
      hw_template_ff      <= template_select;
      hw_loopback_ff      <= loopback_select;
      hw_clock_edge_ff    <= clock_edge_select;
      hw_output_enable_ff <= output_enable_pin;
    end
  end

  // Chip select from the shared pin, only in host modes; a low level means
  // an access. Outside host modes the pin is the attenuator select, so the
  // select is held inactive to keep the host port quiet.
  // The host supplies a fresh falling edge for each access.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_select_n_ff <= 1'h1;  // Inactive during reset
    end else if (serial_port_en_ff || parallel_port_en_ff) begin
      // Only a low code asserts; mid or high leaves the port idle
      chip_select_n_ff <= (chip_select_ja_level == `LVL_LOW) ? 1'h0 : 1'h1;
    end else begin
      chip_select_n_ff <= 1'h1;  // Pin belongs to the hardware setup
    end
  end

  // Address latch on the falling edge of the strobe in multiplexed parallel
  // modes. The previous level resets high, the idle level of the strobe, so
  // no false edge follows reset. Only the low five lines carry address.
  // A strobe that falls in a non-multiplexed mode is ignored.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ale_q_ff           <= 1'h1;
      latched_address_ff <= 5'h00;
    end else begin
      ale_q_ff <= address_latch_strobe;  // Remember the strobe level
      if (parallel_port_en_ff && par_style_ff.multiplexed &&
          ale_q_ff && !address_latch_strobe) begin
        latched_address_ff <= shared_bus[4:0];
      end
    end
  end

endmodule : control_mode_strap_decode
`default_nettype wire

// ==== inc/strap_pkg.sv ====
// Types for the control mode strap decoder
package strap_pkg;
  typedef enum logic [2:0] {
    CTRL_HARDWARE = 3'h1,
    CTRL_SERIAL   = 3'h2,
    CTRL_PARALLEL = 3'h4
  } ctrl_mode_t;
  typedef enum logic [1:0] {
    JA_TRANSMIT = 2'h0,
    JA_RECEIVE  = 2'h1,
    JA_NONE     = 2'h2
  } ja_pos_t;
  typedef struct packed {
    logic multiplexed;  // Shared address/data bus
    logic rw_strobes;   // Separate read and write strobes
  } par_style_t;
  typedef enum logic [2:0] {
    ST_RESET  = 3'h1,
    ST_SETTLE = 3'h2,
    ST_READY  = 3'h4
  } strap_state_t;
endpackage : strap_pkg

// ==== inc/strap_regs.svh ====
// Constants for the control mode strap decoder
`ifndef STRAP_REGS_SVH
`define STRAP_REGS_SVH
`define LVL_LOW       2'h0
`define LVL_MID       2'h1
`define LVL_HIGH      2'h2
`define SETTLE_NS     100
`define CLK_PERIOD_NS 10
`define SETTLE_CYCLES (`SETTLE_NS / `CLK_PERIOD_NS)
`endif

// ==== test/control_mode_strap_decode_test.sv ====
// Testbench for the control mode strap decoder
`timescale 1ns/1ps
`default_nettype none
module control_mode_strap_decode_test import strap_pkg::*;;
  logic clk = 0, reset_n = 0, mx = 0, fm = 0, al = 1, ce = 0, oe = 0;
  logic [1:0] lv = 0, ja = 0;
  logic [7:0] bus = 0, lp = 0;
  logic [2:0] ts = 0;
  wire logic [1:0] msel;
  wire logic mxs, hfs, als;
  logic rdy, se, pe, he, ami, csn;
  ctrl_mode_t cm;
  par_style_t ps;
  ja_pos_t jp;
  logic [4:0] la;
  logic [2:0] ht;
  logic [7:0] hl;
  logic hc, ho;
  int err_count = 0, tests_run = 0;
  always #5 clk = ~clk;
  strap_board i_strap_board (.mode_level(lv), .mux_want(mx), .fam_want(fm), .latch_want(al),
    .control_mode_select_hi(msel), .bus_multiplex_select(mxs), .host_family_select(hfs),
    .address_latch_strobe(als));
  control_mode_strap_decode i_control_mode_strap_decode (.clk(clk), .reset_n(reset_n),
    .control_mode_select_hi(msel), .bus_multiplex_select(mxs), .host_family_select(hfs),
    .chip_select_ja_level(ja), .template_select(ts), .loopback_select(lp), .clock_edge_select(ce),
    .output_enable_pin(oe), .shared_bus(bus), .address_latch_strobe(als), .straps_ready_ff(rdy),
    .ctrl_mode_ff(cm), .par_style_ff(ps), .serial_port_en_ff(se), .parallel_port_en_ff(pe),
    .hw_config_en_ff(he), .ami_select_ff(ami), .ja_pos_ff(jp), .hw_template_ff(ht),
    .hw_loopback_ff(hl), .hw_clock_edge_ff(hc), .hw_output_enable_ff(ho), .chip_select_n_ff(csn),
    .latched_address_ff(la));
  task stop_test;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task boot(input logic [1:0] l, input logic m, f, input logic [1:0] j);
    @(posedge clk) #1;
    {lv, mx, fm, ja, reset_n} = {l, m, f, j, 1'h0};
    repeat (8) @(posedge clk);
    #1 reset_n = 1;
    for (int i = 0; i < 20 && rdy !== 1'h1; i++) @(posedge clk) #1;
    if (rdy !== 1'h1) begin
      err_count++;
      $display("CHECK FAILED %0t straps never ready", $time);
      stop_test();
    end
  endtask : boot
  task step(input int n);
    repeat (n) @(posedge clk) #1;
  endtask : step
  initial begin
    boot(0, 0, 0, 0);
    chk(cm, CTRL_HARDWARE);
    chk(he, 1);
    chk(ami, 0);
    chk(jp, JA_TRANSMIT);
    chk(csn, 1);
    {ts, lp, ce, oe} = {3'h5, 8'hA5, 1'h1, 1'h1};
    step(2);
    chk(ht, 3'h5);
    chk(hl, 8'hA5);
    chk(hc, 1);
    chk(ho, 1);
    boot(0, 0, 1, 1);
    chk(ami, 1);
    chk(jp, JA_RECEIVE);
    boot(1, 1, 1, 2);
    chk(cm, CTRL_SERIAL);
    chk(se, 1);
    lp = 8'h3C;
    step(2);
    chk(hl, 8'h00);
    boot(2, 0, 0, 2);
    chk(cm, CTRL_PARALLEL);
    chk(pe, 1);
    chk(ps, 8'h0);
    boot(2, 1, 0, 2);
    chk(ps, 8'h2);
    boot(3, 0, 1, 2);
    chk(cm, CTRL_PARALLEL);
    chk(ps, 8'h1);
    boot(2, 1, 1, 2);
    chk(ps, 8'h3);
    ja = 0;
    step(2);
    chk(csn, 0);
    {bus, al} = {8'hFB, 1'h0};
    step(2);
    chk(la, 5'h1B);
    {lv, al} = {2'h0, 1'h1};
    step(3);
    chk(cm, CTRL_PARALLEL);
    stop_test();
  end
endmodule : control_mode_strap_decode_test
`default_nettype wire

// ==== test/strap_board.sv ====
// Board strap model that grounds the mux pin except at mode level 2 and the family pin in serial mode, and holds the latch strobe high unless multiplexed
`timescale 1ns/1ps
`default_nettype none
module strap_board (
  input  wire logic [1:0] mode_level,
  input  wire logic       mux_want,
  input  wire logic       fam_want,
  input  wire logic       latch_want,
  output logic [1:0]      control_mode_select_hi,
  output logic            bus_multiplex_select,
  output logic            host_family_select,
  output logic            address_latch_strobe
);
  assign control_mode_select_hi = mode_level;
  assign bus_multiplex_select = (mode_level == 2'h2) & mux_want;
  assign host_family_select = (mode_level != 2'h1) & fam_want;
  assign address_latch_strobe = latch_want | ~bus_multiplex_select;
endmodule : strap_board
`default_nettype wire

// ==== test/strap_decode_assertions.sv ====
// Checker for the control mode strap decoder
`timescale 1ns/1ps
`default_nettype none
module strap_decode_assertions
  import strap_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [1:0] chip_select_ja_level,
  input wire logic [7:0] shared_bus,
  input wire logic       address_latch_strobe,
  input wire logic       straps_ready_ff,
  input wire ctrl_mode_t ctrl_mode_ff,
  input wire par_style_t par_style_ff,
  input wire logic       serial_port_en_ff,
  input wire logic       parallel_port_en_ff,
  input wire logic       hw_config_en_ff,
  input wire logic       ami_select_ff,
  input wire logic       chip_select_n_ff,
  input wire logic [4:0] latched_address_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Host port chip select follows its pin one cycle late
  logic host_en;
  assign host_en = serial_port_en_ff | parallel_port_en_ff;
  a_ready_in_time: assert property ($rose(reset_n) |-> ##[1:12] straps_ready_ff)
    else $error("straps not sampled in time");
  // Falling latch strobe while the multiplexed parallel port is active
  sequence s_latch_fall;
    parallel_port_en_ff && par_style_ff.multiplexed && $fell(address_latch_strobe);
  endsequence
  a_strap_held: assert property (
    straps_ready_ff |=> straps_ready_ff && $stable(ctrl_mode_ff) && $stable(par_style_ff))
    else $error("strap result changed");
  a_hw_pins: assert property (
    straps_ready_ff && ctrl_mode_ff == CTRL_HARDWARE |-> hw_config_en_ff && !host_en)
    else $error("hardware pins not chosen");
  a_serial_pins: assert property (
    straps_ready_ff && ctrl_mode_ff == CTRL_SERIAL |-> serial_port_en_ff && !parallel_port_en_ff)
    else $error("serial pins");
  a_par_pins: assert property (
    straps_ready_ff && ctrl_mode_ff == CTRL_PARALLEL |-> parallel_port_en_ff && !hw_config_en_ff)
    else $error("parallel pins");
  a_cs_follow: assert property (
    host_en && $past(host_en) |-> chip_select_n_ff == ($past(chip_select_ja_level) != 2'h0))
    else $error("chip select");
  a_addr_latch: assert property (
    s_latch_fall |=> latched_address_ff == $past(shared_bus[4:0]))
    else $error("address latch");
  a_ami_host: assert property (!hw_config_en_ff |-> !ami_select_ff) else $error("line code");
endmodule : strap_decode_assertions
bind control_mode_strap_decode strap_decode_assertions i_strap_decode_assertions (.*);
`default_nettype wire
